//--- design/chan_div_pkg.sv
// Purpose: constants and helper functions shared by the channel clock divider block
// Assumes: 8-bit registers, one per 32-bit Avalon word, byte address = index * 4
// Notes:   register indexes are kept as printed; the bus address is four times the index
package chan_div_pkg;

    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned REG_W    = 8;
    localparam int unsigned CNT_W    = 4;
    localparam int unsigned IDX_W    = 10;

    // register indexes
    localparam logic [IDX_W-1:0] IDX_CHAN1_COUNTS     = 10'h196;
    localparam logic [IDX_W-1:0] IDX_CHAN1_CONTROL    = 10'h197;
    localparam logic [IDX_W-1:0] IDX_CHAN1_ROUTING    = 10'h198;
    localparam logic [IDX_W-1:0] IDX_CHAN2_S1_COUNTS  = 10'h199;
    localparam logic [IDX_W-1:0] IDX_CHAN2_PHASES     = 10'h19a;
    localparam logic [IDX_W-1:0] IDX_CHAN2_S2_COUNTS  = 10'h19b;
    localparam logic [IDX_W-1:0] IDX_CHAN2_CONTROL    = 10'h19c;
    localparam logic [IDX_W-1:0] IDX_CHAN2_DUTY       = 10'h19d;
    localparam logic [IDX_W-1:0] IDX_CHAN3_S1_COUNTS  = 10'h19e;
    localparam logic [IDX_W-1:0] IDX_STATUS           = 10'h1a8;

    // count registers: low count high nibble, high count low nibble
    localparam int unsigned LO_MSB = 7;
    localparam int unsigned LO_LSB = 4;
    localparam int unsigned HI_MSB = 3;
    localparam int unsigned HI_LSB = 0;

    // chan1 control
    localparam int unsigned C1_BYPASS_BIT = 7;
    localparam int unsigned C1_NOSYNC_BIT = 6;
    localparam int unsigned C1_FORCE_BIT  = 5;
    localparam int unsigned C1_START_BIT  = 4;
    localparam int unsigned PH_MSB        = 3;
    localparam int unsigned PH_LSB        = 0;

    // chan1 routing
    localparam int unsigned C1_DIRECT_BIT = 1;
    localparam int unsigned DCC_OFF_BIT   = 0;

    // chan2 control
    localparam int unsigned C2_BYPASS2_BIT = 5;
    localparam int unsigned C2_BYPASS1_BIT = 4;
    localparam int unsigned C2_NOSYNC_BIT  = 3;
    localparam int unsigned C2_FORCE_BIT   = 2;
    localparam int unsigned C2_START2_BIT  = 1;
    localparam int unsigned C2_START1_BIT  = 0;

    // chan2 phases
    localparam int unsigned PH2_MSB = 7;
    localparam int unsigned PH2_LSB = 4;

    // clock source select codes
    localparam logic [1:0] SRC_EXT_CLK = 2'b00;
    localparam logic [1:0] SRC_NONE    = 2'b01;
    localparam logic [1:0] SRC_VCO     = 2'b10;

    localparam logic [REG_W-1:0]  REG_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  CNT_ZERO   = 4'h0;

    function automatic logic [IDX_W-1:0] addr_to_idx(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction

    function automatic logic [CNT_W-1:0] lo_field(input logic [REG_W-1:0] r);
        return r[LO_MSB:LO_LSB];
    endfunction

    function automatic logic [CNT_W-1:0] hi_field(input logic [REG_W-1:0] r);
        return r[HI_MSB:HI_LSB];
    endfunction

endpackage

//--- design/div_stage_if.sv
// Purpose: control and clock signals between the register file and one divider stage
// Assumes: single clock domain; divider input clock is carried as a level plus a rise pulse
// Notes:   none
interface div_stage_if;
    import chan_div_pkg::*;
    logic [CNT_W-1:0] lo_cnt;
    logic [CNT_W-1:0] hi_cnt;
    logic [CNT_W-1:0] phase;
    logic             start_high;
    logic             bypass;
    logic             sync;
    logic             in_lvl;
    logic             in_rise;
    logic             out_lvl;
    logic             out_rise;

    modport ctrl  (output lo_cnt, hi_cnt, phase, start_high, bypass, sync, in_lvl, in_rise,
                   input out_lvl, out_rise);
    modport stage (input lo_cnt, hi_cnt, phase, start_high, bypass, sync, in_lvl, in_rise,
                   output out_lvl, out_rise);
endinterface

//--- design/clk_div_stage.sv
// Purpose: one integer divider stage with low/high counts, phase offset, start level, bypass
// Assumes: in_rise pulses once per divider input clock period
// Notes:   bypass idles the counter and passes the input clock through
module clk_div_stage
    import chan_div_pkg::*;
(
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    div_stage_if.stage port_s
);

    typedef struct packed {
        logic             lvl;
        logic             rise;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] phase_cnt;
    } stage_state_t;

    stage_state_t st_ff;
    stage_state_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.rise = 1'b0;
        if (port_s.bypass) begin
            // powered down: hold idle
            nxt_st = '0;
        end else if (port_s.sync) begin
            nxt_st.lvl       = port_s.start_high;
            nxt_st.cnt       = CNT_ZERO;
            nxt_st.phase_cnt = port_s.phase;
            nxt_st.rise      = port_s.start_high & ~st_ff.lvl;
        end else if (port_s.in_rise) begin
            if (st_ff.phase_cnt != CNT_ZERO) begin
                nxt_st.phase_cnt = st_ff.phase_cnt - 4'h1;
            end else if (!st_ff.lvl) begin
                if (st_ff.cnt == port_s.lo_cnt) begin
                    nxt_st.lvl  = 1'b1;
                    nxt_st.cnt  = CNT_ZERO;
                    nxt_st.rise = 1'b1;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                end
            end else begin
                if (st_ff.cnt == port_s.hi_cnt) begin
                    nxt_st.lvl = 1'b0;
                    nxt_st.cnt = CNT_ZERO;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign port_s.out_lvl  = port_s.bypass ? port_s.in_lvl  : st_ff.lvl;
    assign port_s.out_rise = port_s.bypass ? port_s.in_rise : st_ff.rise;

endmodule // clk_div_stage

//--- design/chan_clk_div.sv
// Purpose: register file and channel dividers for three output channels
// Assumes: Avalon-MM slave, one-cycle waitrequest; divider input is ref_clk_i / 2
// Notes:   vco and external clock pins are synchronised before routing
module chan_clk_div
    import chan_div_pkg::*;
(
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic [chan_div_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                           avs_read_i,
    input  wire logic                           avs_write_i,
    input  wire logic [chan_div_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]                     avs_byteenable_i,
    output logic      [chan_div_pkg::DATA_W-1:0] avs_readdata_o,
    output logic                                avs_waitrequest_o,
    input  wire logic                           chip_sync_i,
    input  wire logic [1:0]                     clk_src_sel_i,
    input  wire logic                           vco_clk_i,
    input  wire logic                           ext_clk_i,
    output logic                                diff_output_a_o,
    output logic                                diff_output_b_o,
    output logic                                chan2_out_o,
    output logic                                chan3_out_o,
    output logic [2:0]                          duty_corr_en_o
);
    import chan_div_pkg::*;

    typedef struct packed {
        logic [REG_W-1:0]  chan1_counts;
        logic [REG_W-1:0]  chan1_divider_control;
        logic [REG_W-1:0]  chan1_output_routing;
        logic [REG_W-1:0]  chan2_stage1_counts;
        logic [REG_W-1:0]  chan2_phase_offsets;
        logic [REG_W-1:0]  chan2_stage2_counts;
        logic [REG_W-1:0]  chan2_divider_control;
        logic [REG_W-1:0]  chan2_duty_correction;
        logic [REG_W-1:0]  chan3_stage1_counts;
        logic              ack;
        logic [DATA_W-1:0] rdata;
        logic              src_lvl;
        logic              vco_meta;
        logic              vco_sync;
        logic              ext_meta;
        logic              ext_sync;
        logic              out_a;
        logic              out_b;
        logic              out_c2;
        logic              out_c3;
        logic [2:0]        dcc_en;
    } top_state_t;

    top_state_t st_ff;
    top_state_t nxt_st;

    div_stage_if c1_if ();
    div_stage_if c2s1_if ();
    div_stage_if c2s2_if ();
    div_stage_if c3s1_if ();

    logic [IDX_W-1:0] req_idx;
    logic             req;
    logic             c1_nosync;
    logic             c2_nosync;
    logic             c1_div_out;
    logic             c2_div_out;

    assign req_idx = addr_to_idx(avs_address_i);
    assign req     = avs_read_i | avs_write_i;

    assign c1_nosync = st_ff.chan1_divider_control[C1_NOSYNC_BIT];
    assign c2_nosync = st_ff.chan2_divider_control[C2_NOSYNC_BIT];

    // chan1 divider
    assign c1_if.lo_cnt     = lo_field(st_ff.chan1_counts);
    assign c1_if.hi_cnt     = hi_field(st_ff.chan1_counts);
    assign c1_if.phase      = st_ff.chan1_divider_control[PH_MSB:PH_LSB];
    assign c1_if.start_high = st_ff.chan1_divider_control[C1_START_BIT];
    assign c1_if.bypass     = st_ff.chan1_divider_control[C1_BYPASS_BIT];
    assign c1_if.sync       = chip_sync_i & ~c1_nosync;
    assign c1_if.in_lvl     = st_ff.src_lvl;
    assign c1_if.in_rise    = st_ff.src_lvl;

    // chan2 cascade: stage 1 feeds stage 2
    assign c2s1_if.lo_cnt     = lo_field(st_ff.chan2_stage1_counts);
    assign c2s1_if.hi_cnt     = hi_field(st_ff.chan2_stage1_counts);
    assign c2s1_if.phase      = st_ff.chan2_phase_offsets[PH_MSB:PH_LSB];
    assign c2s1_if.start_high = st_ff.chan2_divider_control[C2_START1_BIT];
    assign c2s1_if.bypass     = st_ff.chan2_divider_control[C2_BYPASS1_BIT];
    assign c2s1_if.sync       = chip_sync_i & ~c2_nosync;
    assign c2s1_if.in_lvl     = st_ff.src_lvl;
    assign c2s1_if.in_rise    = st_ff.src_lvl;

    assign c2s2_if.lo_cnt     = lo_field(st_ff.chan2_stage2_counts);
    assign c2s2_if.hi_cnt     = hi_field(st_ff.chan2_stage2_counts);
    assign c2s2_if.phase      = st_ff.chan2_phase_offsets[PH2_MSB:PH2_LSB];
    assign c2s2_if.start_high = st_ff.chan2_divider_control[C2_START2_BIT];
    assign c2s2_if.bypass     = st_ff.chan2_divider_control[C2_BYPASS2_BIT];
    assign c2s2_if.sync       = chip_sync_i & ~c2_nosync;
    assign c2s2_if.in_lvl     = c2s1_if.out_lvl;
    assign c2s2_if.in_rise    = c2s1_if.out_rise;

    // chan3 first stage: counts only, other controls at their defaults
    assign c3s1_if.lo_cnt     = lo_field(st_ff.chan3_stage1_counts);
    assign c3s1_if.hi_cnt     = hi_field(st_ff.chan3_stage1_counts);
    assign c3s1_if.phase      = CNT_ZERO;
    assign c3s1_if.start_high = 1'b0;
    assign c3s1_if.bypass     = 1'b0;
    assign c3s1_if.sync       = chip_sync_i;
    assign c3s1_if.in_lvl     = st_ff.src_lvl;
    assign c3s1_if.in_rise    = st_ff.src_lvl;

    clk_div_stage u_c1 (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .port_s    (c1_if.stage)
    );

    clk_div_stage u_c2s1 (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .port_s    (c2s1_if.stage)
    );

    clk_div_stage u_c2s2 (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .port_s    (c2s2_if.stage)
    );

    clk_div_stage u_c3s1 (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .port_s    (c3s1_if.stage)
    );

    // static forcing only with nosync set
    always_comb begin
        if (c1_nosync && st_ff.chan1_divider_control[C1_FORCE_BIT]) begin
            c1_div_out = 1'b1;
        end else begin
            c1_div_out = c1_if.out_lvl;
        end
        if (c2_nosync && st_ff.chan2_divider_control[C2_FORCE_BIT]) begin
            c2_div_out = 1'b1;
        end else begin
            c2_div_out = c2s2_if.out_lvl;
        end
    end

    always_comb begin
        nxt_st = st_ff;

        // divider input clock model: toggles at every rising ref_clk_i edge
        nxt_st.src_lvl = ~st_ff.src_lvl;

        nxt_st.vco_meta = vco_clk_i;
        nxt_st.vco_sync = st_ff.vco_meta;
        nxt_st.ext_meta = ext_clk_i;
        nxt_st.ext_sync = st_ff.ext_meta;

        // chan1 output routing
        nxt_st.out_a = c1_div_out;
        if (st_ff.chan1_output_routing[C1_DIRECT_BIT]) begin
            case (clk_src_sel_i)
                SRC_VCO:     nxt_st.out_a = st_ff.vco_sync;
                SRC_EXT_CLK: nxt_st.out_a = st_ff.ext_sync;
                default:     nxt_st.out_a = c1_div_out;
            endcase
        end
        nxt_st.out_b  = nxt_st.out_a;
        nxt_st.out_c2 = c2_div_out;
        nxt_st.out_c3 = c3s1_if.out_lvl;

        nxt_st.dcc_en[0] = ~st_ff.chan1_output_routing[DCC_OFF_BIT];
        nxt_st.dcc_en[1] = ~st_ff.chan2_duty_correction[DCC_OFF_BIT];
        nxt_st.dcc_en[2] = 1'b1;

        // bus: answer one cycle after the request is seen
        nxt_st.ack = req & ~st_ff.ack;

        // writes leave the last read data standing
        if (req && !st_ff.ack) begin
            if (avs_read_i) begin
                nxt_st.rdata = DATA_ZERO;
                case (req_idx)
                    IDX_CHAN1_COUNTS:    nxt_st.rdata[REG_W-1:0] = st_ff.chan1_counts;
                    IDX_CHAN1_CONTROL:   nxt_st.rdata[REG_W-1:0] = st_ff.chan1_divider_control;
                    IDX_CHAN1_ROUTING:   nxt_st.rdata[REG_W-1:0] = st_ff.chan1_output_routing;
                    IDX_CHAN2_S1_COUNTS: nxt_st.rdata[REG_W-1:0] = st_ff.chan2_stage1_counts;
                    IDX_CHAN2_PHASES:    nxt_st.rdata[REG_W-1:0] = st_ff.chan2_phase_offsets;
                    IDX_CHAN2_S2_COUNTS: nxt_st.rdata[REG_W-1:0] = st_ff.chan2_stage2_counts;
                    IDX_CHAN2_CONTROL:   nxt_st.rdata[REG_W-1:0] = st_ff.chan2_divider_control;
                    IDX_CHAN2_DUTY:      nxt_st.rdata[REG_W-1:0] = st_ff.chan2_duty_correction;
                    IDX_CHAN3_S1_COUNTS: nxt_st.rdata[REG_W-1:0] = st_ff.chan3_stage1_counts;
                    IDX_STATUS: begin
                        nxt_st.rdata[0] = st_ff.out_a;
                        nxt_st.rdata[1] = st_ff.out_c2;
                        nxt_st.rdata[2] = st_ff.out_c3;
                        nxt_st.rdata[3] = c2s1_if.out_lvl;
                        nxt_st.rdata[6:4] = st_ff.dcc_en;
                    end
                    default:             nxt_st.rdata = DATA_ZERO;
                endcase
            end
        end

        // writes take effect at the edge where waitrequest is low
        if (avs_write_i && st_ff.ack && avs_byteenable_i[0]) begin
            case (req_idx)
                IDX_CHAN1_COUNTS:    nxt_st.chan1_counts          = avs_writedata_i[REG_W-1:0];
                IDX_CHAN1_CONTROL:   nxt_st.chan1_divider_control = avs_writedata_i[REG_W-1:0];
                IDX_CHAN1_ROUTING:   nxt_st.chan1_output_routing  = {6'h00, avs_writedata_i[1:0]};
                IDX_CHAN2_S1_COUNTS: nxt_st.chan2_stage1_counts   = avs_writedata_i[REG_W-1:0];
                IDX_CHAN2_PHASES:    nxt_st.chan2_phase_offsets   = avs_writedata_i[REG_W-1:0];
                IDX_CHAN2_S2_COUNTS: nxt_st.chan2_stage2_counts   = avs_writedata_i[REG_W-1:0];
                IDX_CHAN2_CONTROL:   nxt_st.chan2_divider_control = {2'h0, avs_writedata_i[5:0]};
                IDX_CHAN2_DUTY:      nxt_st.chan2_duty_correction = {7'h00, avs_writedata_i[0]};
                IDX_CHAN3_S1_COUNTS: nxt_st.chan3_stage1_counts   = avs_writedata_i[REG_W-1:0];
                default:             nxt_st.chan3_stage1_counts   = st_ff.chan3_stage1_counts;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_waitrequest_o = req & ~st_ff.ack;
    assign avs_readdata_o    = st_ff.rdata;
    assign diff_output_a_o   = st_ff.out_a;
    assign diff_output_b_o   = st_ff.out_b;
    assign chan2_out_o       = st_ff.out_c2;
    assign chan3_out_o       = st_ff.out_c3;
    assign duty_corr_en_o    = st_ff.dcc_en;

endmodule // chan_clk_div

//--- testbench/chan_clk_div_chk.sv
// Purpose: concurrent checks on the ports of chan_clk_div
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of chan_clk_div
module chan_clk_div_chk
    import chan_div_pkg::*;
(
    input wire logic                            ref_clk_i,
    input wire logic                            rst_n_i,
    input wire logic [chan_div_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic                            avs_read_i,
    input wire logic                            avs_write_i,
    input wire logic [chan_div_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0]                      avs_byteenable_i,
    input wire logic [chan_div_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic                            avs_waitrequest_o,
    input wire logic                            chip_sync_i,
    input wire logic [1:0]                      clk_src_sel_i,
    input wire logic                            vco_clk_i,
    input wire logic                            ext_clk_i,
    input wire logic                            diff_output_a_o,
    input wire logic                            diff_output_b_o,
    input wire logic                            chan2_out_o,
    input wire logic                            chan3_out_o,
    input wire logic [2:0]                      duty_corr_en_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic req;
    assign req = avs_read_i | avs_write_i;
    sequence s_wait; req && avs_waitrequest_o; endsequence
    sequence s_sync; chip_sync_i; endsequence
    chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
        else $error("waitrequest low in first request cycle");
    chk_wait_single: assert property (s_wait ##1 req |-> !avs_waitrequest_o)
        else $error("request not answered in second cycle");
    chk_wait_needs_req: assert property (avs_waitrequest_o |-> req)
        else $error("waitrequest without request");
    chk_rdata_upper: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    chk_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
        else $error("read data changed without read");
    chk_pair_equal: assert property (diff_output_a_o == diff_output_b_o)
        else $error("output pair differs");
    chk_chan3_dcc: assert property ($past(rst_n_i) |-> duty_corr_en_o[2])
        else $error("chan3 duty correction not enabled");
    chk_sync_start: assert property (s_sync |-> ##2 (!chan3_out_o) [*2])
        else $error("chan3 did not restart low after sync");
endmodule // chan_clk_div_chk

bind chan_clk_div chan_clk_div_chk u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .chip_sync_i(chip_sync_i), .clk_src_sel_i(clk_src_sel_i), .vco_clk_i(vco_clk_i), .ext_clk_i(ext_clk_i),
    .diff_output_a_o(diff_output_a_o), .diff_output_b_o(diff_output_b_o), .chan2_out_o(chan2_out_o),
    .chan3_out_o(chan3_out_o), .duty_corr_en_o(duty_corr_en_o));

//--- testbench/testbench.sv
// Purpose: self-checking bench for chan_clk_div
// Assumes: Avalon-MM master model below, 250 MHz clock
// Notes:   divider waveforms measured in ref clock cycles at falling edges
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import chan_div_pkg::*;
    logic        ref_clk_i, rst_n_i, avs_read_i, avs_write_i, chip_sync_i, vco_clk_i, ext_clk_i;
    logic [11:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    logic [3:0]  avs_byteenable_i;
    logic [1:0]  clk_src_sel_i;
    logic        avs_waitrequest_o, diff_output_a_o, diff_output_b_o, chan2_out_o, chan3_out_o;
    logic [2:0]  duty_corr_en_o;
    int          errors, checks, hi, lo, d0, d1;
    typedef struct {int w; logic [9:0] idx; logic [7:0] wd; int hi; int lo;} row_t;
    row_t rows[12] = '{'{0, 10'h196, 8'ha5, 0, 0}, '{0, 10'h197, 8'h5a, 0, 0}, '{0, 10'h198, 8'hff, 0, 8'h03},
        '{0, 10'h199, 8'h37, 0, 0}, '{0, 10'h19a, 8'h21, 0, 0}, '{0, 10'h19b, 8'h45, 0, 0},
        '{0, 10'h19c, 8'hff, 0, 8'h3f}, '{0, 10'h19d, 8'hff, 0, 8'h01}, '{0, 10'h19e, 8'h9c, 0, 0},
        '{0, 10'h1b0, 8'hff, 0, 8'h00}, '{0, 10'h1a8, 8'hff, 0, 8'h70}, '{0, 10'h196, 8'h00, 0, 0}};
    row_t wav[12] = '{'{2, 10'h19e, 8'h00, 2, 2}, '{2, 10'h19e, 8'h21, 4, 6}, '{2, 10'h19e, 8'hf0, 2, 32},
        '{0, 10'h196, 8'h0f, 32, 2}, '{0, 10'h196, 8'h00, 2, 2}, '{1, 10'h199, 8'h10, 6, 6},
        '{1, 10'h19b, 8'h01, 12, 6}, '{1, 10'h199, 8'h00, 8, 4}, '{1, 10'h19c, 8'h20, 2, 2},
        '{1, 10'h19c, 8'h10, 4, 2}, '{1, 10'h19c, 8'h30, 1, 1}, '{1, 10'h19c, 8'h08, 8, 4}};

    chan_clk_div dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .chip_sync_i(chip_sync_i), .clk_src_sel_i(clk_src_sel_i), .vco_clk_i(vco_clk_i), .ext_clk_i(ext_clk_i),
        .diff_output_a_o(diff_output_a_o), .diff_output_b_o(diff_output_b_o), .chan2_out_o(chan2_out_o),
        .chan3_out_o(chan3_out_o), .duty_corr_en_o(duty_corr_en_o));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one Avalon transfer; request held until the rising edge at which waitrequest is sampled low
    task bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        int n;
        @(posedge ref_clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {24'h00_0000, wd};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        n = 0;
        do begin @(posedge ref_clk_i); n++; end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin errors++; summarize(); end
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    function automatic logic sig(input int w);
        return (w == 0) ? diff_output_a_o : (w == 1) ? chan2_out_o : chan3_out_o;
    endfunction
    task wait_lvl(input int w, input logic v, output int n);
        n = 0;
        while (sig(w) !== v && n < 400) begin @(negedge ref_clk_i); n++; end
        if (n >= 400) begin errors++; summarize(); end
    endtask
    // third full period after a change is measured, the first two may be transitions
    task measure(input int w);
        int n;
        repeat (2) begin
            wait_lvl(w, 1'b0, n);
            wait_lvl(w, 1'b1, n);
            hi = 0;
            lo = 0;
            while (sig(w) === 1'b1 && hi < 400) begin @(negedge ref_clk_i); hi++; end
            while (sig(w) === 1'b0 && lo < 400) begin @(negedge ref_clk_i); lo++; end
        end
    endtask
    task sync_pulse;
        @(posedge ref_clk_i) chip_sync_i <= 1'b1;
        @(posedge ref_clk_i) chip_sync_i <= 1'b0;
    endtask
    // first rise of channel w after a sync, relative to chan3 restarting from the same pulse
    task sync_delay(input int w, output int d);
        int tw, t3;
        tw = -1;
        t3 = -1;
        sync_pulse();
        repeat (2) @(negedge ref_clk_i);
        for (int k = 0; k < 100; k++) begin
            if (tw < 0 && sig(w) === 1'b1) tw = k;
            if (t3 < 0 && chan3_out_o === 1'b1) t3 = k;
            @(negedge ref_clk_i);
        end
        if (tw < 0 || t3 < 0) begin errors++; summarize(); end
        d = tw - t3;
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        {rst_n_i, avs_read_i, avs_write_i, chip_sync_i, vco_clk_i, ext_clk_i} = 6'h00;
        avs_address_i = 12'h000;
        avs_writedata_i = 32'h0000_0000;
        avs_byteenable_i = 4'hf;
        clk_src_sel_i = 2'b01;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        check(duty_corr_en_o, 3'b111);
        for (int i = 0; i < 10; i++) begin
            bus(1'b0, rows[i].idx, 8'h00);
            check(rd, 32'h0000_0000);
            bus(1'b1, rows[i].idx, rows[i].wd);
            bus(1'b0, rows[i].idx, 8'h00);
            check(rd, (rows[i].lo != 0 || i == 9) ? rows[i].lo : rows[i].wd);
            bus(1'b1, rows[i].idx, 8'h00);
        end
        $display("register table done");
        avs_byteenable_i <= 4'h0;
        bus(1'b1, 10'h196, 8'hff);
        avs_byteenable_i <= 4'hf;
        bus(1'b0, 10'h196, 8'h00);
        check(rd, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            bus(1'b1, wav[i].idx, wav[i].wd);
            measure(wav[i].w);
            check(hi, wav[i].hi);
            check(lo, wav[i].lo);
        end
        bus(1'b1, 10'h19c, 8'h0c);
        repeat (8) @(posedge ref_clk_i);
        d0 = 0;
        repeat (20) begin @(negedge ref_clk_i); d0 += chan2_out_o; end
        check(d0, 20);
        bus(1'b1, 10'h19c, 8'h04);
        measure(1);
        check(hi, 8);
        $display("waveform table done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, (i < 2) ? 10'h197 : 10'h19c, (i == 0) ? 8'h10 : (i == 2) ? 8'h03 : 8'h00);
            sync_pulse();
            @(posedge ref_clk_i);
            #1 check(sig(i / 2), !i[0]);
        end
        sync_delay(0, d0);
        bus(1'b1, 10'h197, 8'h03);
        sync_delay(0, d1);
        check(d1 - d0, 6);
        sync_delay(1, d0);
        bus(1'b1, 10'h19a, 8'h30);
        sync_delay(1, d1);
        check(d1 - d0, 12);
        $display("sync and phase done");
        bus(1'b1, 10'h198, 8'h03);
        repeat (2) @(negedge ref_clk_i);
        check(duty_corr_en_o, 3'b110);
        bus(1'b1, 10'h19d, 8'h01);
        repeat (2) @(negedge ref_clk_i);
        check(duty_corr_en_o, 3'b100);
        for (int i = 0; i < 4; i++) begin
            clk_src_sel_i <= i[0] ? 2'b00 : 2'b10;
            {vco_clk_i, ext_clk_i} <= i[1] ? 2'b01 : 2'b10;
            repeat (6) @(posedge ref_clk_i);
            check(diff_output_a_o, i[0] ^ i[1] ? 1'b0 : 1'b1);
        end
        clk_src_sel_i <= 2'b01;
        bus(1'b1, 10'h197, 8'h00);
        measure(0);
        check(hi, 2);
        $display("routing done");
        summarize();
    end
endmodule // testbench
